// file: core/bst_pkg.sv
// Purpose: Shared constants and types for the boundary-scan test access port.
// Assumes: All test port inputs are sampled by ref_clk through two flip-flops.
// Notes:   Instruction codes are chosen locally; all-ones selects bypass.
//
// What this block does
// - Sample/preload captures pin states into boundary register without disturbing core operation.
// - Sample/preload lets the controller shift a pattern in for later use at pins.
// - External test drives outputs from boundary register and captures input pins.
// - Bypass puts a one-bit register between serial test input and output.
// - Bypass moves one bit per test clock while the core keeps running.
// - Instruction register is exactly three bits; three bits shift per load.
// - Boundary register length is a variant parameter: 273, 417, 465 or 645.
// - Undriven test port inputs read high because of weak pull-ups.

package bst_pkg;

  // ------------------------------------------------------------------
  // Register sizes
  // ------------------------------------------------------------------
  localparam int IR_LEN = 3;
  localparam int BSR_LEN_DEFAULT = 273;

  // ------------------------------------------------------------------
  // Instruction codes and reset values
  // ------------------------------------------------------------------
  localparam logic [IR_LEN-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_LEN-1:0] INS_SAMPLE = 3'h5;
  localparam logic [IR_LEN-1:0] INS_BYPASS = 3'h7;
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic PIN_IDLE_LEVEL = 1'b1;

  // ------------------------------------------------------------------
  // Controller states
  // ------------------------------------------------------------------
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } bst_state_t;

endpackage

// file: core/bst_chain.sv
// Purpose: Boundary register: capture stage, shift chain and update stage.
// Assumes: Strobes are one ref_clk cycle wide and never overlap.
// Notes:   Update stage holds the pattern shown at pins in external test.

`timescale 1ns/1ns
`default_nettype none

module bst_chain #(
  parameter int LEN = bst_pkg::BSR_LEN_DEFAULT
) (
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  input  wire logic           capture,
  input  wire logic           shift,
  input  wire logic           update,
  input  wire logic           sin,
  input  wire logic [LEN-1:0] par_in,
  output logic                sout,
  output logic      [LEN-1:0] upd_q
);

  logic [LEN-1:0] chain;
  logic [LEN-1:0] next_chain;
  logic [LEN-1:0] next_upd_q;

  // ------------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------------
  always_comb
  begin
    next_chain = chain;
    next_upd_q = upd_q;
    if (capture)
    begin
      next_chain = par_in;
    end
    else if (shift)
    begin
      next_chain = {sin, chain[LEN-1:1]};
    end
    if (update)
    begin
      next_upd_q = chain;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chain <= '0;
      upd_q <= '0;
    end
    else
    begin
      chain <= next_chain;
      upd_q <= next_upd_q;
    end
  end

  assign sout = chain[0];

endmodule

`default_nettype wire

// file: core/bst_tap.sv
// Purpose: Test access port controller with instruction, bypass and boundary registers.
// Assumes: Test clock is far slower than ref_clk and is found by edge detection.
// Notes:   Port and pin inputs pass two flip-flops; test port inputs reset to the pulled-up high, pin_in copies reset low.

`timescale 1ns/1ns
`default_nettype none

module bst_tap #(
  parameter int BSR_LEN = bst_pkg::BSR_LEN_DEFAULT
) (
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  input  wire logic [BSR_LEN-1:0] pin_in,
  input  wire logic [BSR_LEN-1:0] core_out,
  output logic      [BSR_LEN-1:0] pin_out,
  output logic      [2:0]         ir_active
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic bst_pkg::bst_state_t step(input bst_pkg::bst_state_t s, input logic m);
    case (s)
      bst_pkg::ST_RESET:    step = m ? bst_pkg::ST_RESET   : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE:     step = m ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR:   step = m ? bst_pkg::ST_SEL_IR  : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR:   step = m ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_SHIFT_DR: step = m ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_EXIT1_DR: step = m ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_PAUSE_DR: step = m ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_EXIT2_DR: step = m ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_UPD_DR:   step = m ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR:   step = m ? bst_pkg::ST_RESET   : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR:   step = m ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_SHIFT_IR: step = m ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_EXIT1_IR: step = m ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_PAUSE_IR: step = m ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_EXIT2_IR: step = m ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_UPD_IR:   step = m ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      default:              step = bst_pkg::ST_RESET;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0]         sync1;
  logic [2:0]         sync2;
  logic               tck_prev;
  logic [BSR_LEN-1:0] pin_s1;
  logic [BSR_LEN-1:0] pin_s2;

  // Test port inputs reset high so an undriven, pulled-up pin never looks low; pin_in copies reset low.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1    <= {3{bst_pkg::PIN_IDLE_LEVEL}};
      sync2    <= {3{bst_pkg::PIN_IDLE_LEVEL}};
      tck_prev <= bst_pkg::PIN_IDLE_LEVEL;
      pin_s1   <= '0;
      pin_s2   <= '0;
    end
    else
    begin
      sync1    <= {tck, tms, tdi};
      sync2    <= sync1;
      tck_prev <= sync2[2];
      pin_s1   <= pin_in;
      pin_s2   <= pin_s1;
    end
  end

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_rise;
  logic tck_fall;

  assign tck_s    = sync2[2];
  assign tms_s    = sync2[1];
  assign tdi_s    = sync2[0];
  assign tck_rise = tck_s & ~tck_prev;
  assign tck_fall = ~tck_s & tck_prev;

  // ------------------------------------------------------------------
  // Controller, instruction and bypass registers
  // ------------------------------------------------------------------
  bst_pkg::bst_state_t state;
  bst_pkg::bst_state_t next_state;
  logic [2:0]          ir_sr;
  logic [2:0]          next_ir_sr;
  logic [2:0]          next_ir_active;
  logic                bypass;
  logic                next_bypass;
  logic                next_tdo;
  logic                next_tdo_oe;
  logic                bsr_sel;
  logic                extest;
  logic                bsr_sout;

  // External test and sample pick the boundary register; anything else reads as bypass.
  assign extest  = (ir_active == bst_pkg::INS_EXTEST);
  assign bsr_sel = extest | (ir_active == bst_pkg::INS_SAMPLE);

  always_comb
  begin
    next_state     = state;
    next_ir_sr     = ir_sr;
    next_ir_active = ir_active;
    next_bypass    = bypass;
    next_tdo       = tdo;
    next_tdo_oe    = tdo_oe;
    if (tck_rise)
    begin
      next_state = step(state, tms_s);
      case (state)
        bst_pkg::ST_CAP_IR:   next_ir_sr = bst_pkg::IR_CAPTURE_VAL;
        bst_pkg::ST_SHIFT_IR: next_ir_sr = {tdi_s, ir_sr[2:1]};
        bst_pkg::ST_CAP_DR:   next_bypass = 1'b0;
        bst_pkg::ST_SHIFT_DR: next_bypass = tdi_s;
        default:              next_bypass = bypass;
      endcase
    end
    if (tck_fall)
    begin
      next_tdo_oe = (state == bst_pkg::ST_SHIFT_DR) || (state == bst_pkg::ST_SHIFT_IR);
      if (state == bst_pkg::ST_SHIFT_IR)
      begin
        next_tdo = ir_sr[0];
      end
      else if (state == bst_pkg::ST_SHIFT_DR)
      begin
        next_tdo = bsr_sel ? bsr_sout : bypass;
      end
      if (state == bst_pkg::ST_UPD_IR)
      begin
        next_ir_active = ir_sr;
      end
      // Test-Logic-Reset restores bypass on the falling edge, as Update-IR loads, so the instruction moves on one edge.
      else if (state == bst_pkg::ST_RESET)
      begin
        next_ir_active = bst_pkg::INS_BYPASS;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state     <= bst_pkg::ST_RESET;
      ir_sr     <= '0;
      ir_active <= bst_pkg::INS_BYPASS;
      bypass    <= 1'b0;
      tdo       <= 1'b0;
      tdo_oe    <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      ir_sr     <= next_ir_sr;
      ir_active <= next_ir_active;
      bypass    <= next_bypass;
      tdo       <= next_tdo;
      tdo_oe    <= next_tdo_oe;
    end
  end

  // ------------------------------------------------------------------
  // Boundary register
  // ------------------------------------------------------------------
  logic               bsr_cap;
  logic               bsr_shift;
  logic               bsr_upd;
  logic [BSR_LEN-1:0] bsr_upd_q;
  logic [BSR_LEN-1:0] next_pin_out;

  assign bsr_cap   = tck_rise & bsr_sel & (state == bst_pkg::ST_CAP_DR);
  assign bsr_shift = tck_rise & bsr_sel & (state == bst_pkg::ST_SHIFT_DR);
  assign bsr_upd   = tck_fall & bsr_sel & (state == bst_pkg::ST_UPD_DR);

  bst_chain #(
    .LEN (BSR_LEN)
  ) u_chain (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .capture (bsr_cap),
    .shift   (bsr_shift),
    .update  (bsr_upd),
    .sin     (tdi_s),
    .par_in  (pin_s2),
    .sout    (bsr_sout),
    .upd_q   (bsr_upd_q)
  );

  // Only external test takes the pins away from the core; sample leaves them alone.
  always_comb
  begin
    next_pin_out = extest ? bsr_upd_q : core_out;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out <= '0;
    end
    else
    begin
      pin_out <= next_pin_out;
    end
  end

endmodule

`default_nettype wire

// file: testbench/bst_tap_monitor.sv
// Purpose: Concurrent checks on the test access port pins.
// Assumes: tck is slow against ref_clk and is seen through its edges.
// Notes:   fall_cnt counts ref_clk cycles since tck last fell.
`timescale 1ns/1ns
`default_nettype none
module bst_tap_monitor #(
  parameter int BSR_LEN = bst_pkg::BSR_LEN_DEFAULT
) (
  input wire logic               ref_clk,
  input wire logic               resetn,
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tdi,
  input wire logic               tdo,
  input wire logic               tdo_oe,
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic [BSR_LEN-1:0] core_out,
  input wire logic [BSR_LEN-1:0] pin_out,
  input wire logic [2:0]         ir_active
);
  logic       tck_d;
  logic [3:0] fall_cnt;
  logic [3:0] next_fall;
  logic [2:0] hi_cnt;
  logic [2:0] next_hi;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Edge bookkeeping
  // ------------------------------------------------------------
  always_comb
  begin
    next_fall = (fall_cnt == 4'hf) ? fall_cnt : fall_cnt + 4'h1;
    next_hi   = hi_cnt;
    if (tck_d && !tck)
      next_fall = 4'h0;
    if (tck && !tck_d)
      next_hi = !tms ? 3'h0 : (hi_cnt == 3'h7) ? hi_cnt : hi_cnt + 3'h1;
  end
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tck_d    <= 1'b1;
      fall_cnt <= 4'hf;
      hi_cnt   <= 3'h0;
    end
    else
    begin
      tck_d    <= tck;
      fall_cnt <= next_fall;
      hi_cnt   <= next_hi;
    end
  end
  sequence s_tck_low;
    !tck ##1 !tck;
  endsequence
  chk_tdo_after_fall: assert property (!$stable(tdo) || !$stable(tdo_oe) |-> fall_cnt <= 4'h5)
    else $error("tdo moved away from a tck fall");
  chk_oe_rise_low: assert property ($rose(tdo_oe) |-> s_tck_low)
    else $error("tdo_oe rose while tck high");
  chk_oe_off_exit: assert property (hi_cnt >= 3'h2 && fall_cnt == 4'h5 |-> !tdo_oe)
    else $error("tdo_oe high outside shift");
  chk_ir_after_fall: assert property (!$stable(ir_active) |-> fall_cnt <= 4'h5)
    else $error("instruction changed away from a tck fall");
  chk_tms_reset: assert property (hi_cnt >= 3'h5 && fall_cnt == 4'h5 |-> ir_active == bst_pkg::INS_BYPASS)
    else $error("tms high did not reset the instruction");
  chk_ir_reset_val: assert property ($rose(resetn) |-> ir_active == bst_pkg::INS_BYPASS)
    else $error("instruction after reset is not bypass");
  chk_pins_follow_core: assert property ($past(resetn) && ir_active != bst_pkg::INS_EXTEST &&
    $past(ir_active) != bst_pkg::INS_EXTEST |-> pin_out == $past(core_out))
    else $error("pins do not follow the core");
  chk_extest_pins: assert property (ir_active == bst_pkg::INS_EXTEST &&
    $past(ir_active) == bst_pkg::INS_EXTEST && !$stable(pin_out) |-> fall_cnt <= 4'h5)
    else $error("pins moved under external test without update");
endmodule
bind bst_tap bst_tap_monitor #(.BSR_LEN(BSR_LEN)) mon (.ref_clk(ref_clk), .resetn(resetn), .tck(tck),
  .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
  .pin_out(pin_out), .ir_active(ir_active));
`default_nettype wire

// file: testbench/bst_ctl_model.sv
// Purpose: Board-level scan controller that clocks the test port.
// Assumes: Every shift or float_tms call starts just after a ref_clk rising edge in Run-Idle.
// Notes:   tck is 48 ns and stands low between frames.
`timescale 1ns/1ns
`default_nettype none
module bst_ctl_model #(
  parameter int N = 273
) (
  input wire logic ref_clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic     tck_o,
  output logic     tms_o,
  output logic     tms_oe,
  output logic     tdi_o
);
  initial
  begin
    tck_o  = 1'b0;
    tms_o  = 1'b1;
    tms_oe = 1'b1;
    tdi_o  = 1'b1;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    repeat (6) @(posedge ref_clk);
    // A released output shows the inverse of its last value, so a missing enable is caught.
    q = tdo_oe ? tdo : ~tdo;
    tck_o <= 1'b1;
    repeat (6) @(posedge ref_clk);
    tck_o <= 1'b0;
  endtask
  // Walks Run-Idle to a shift state, moves n bits LSB first, updates, back to Run-Idle.
  task automatic shift(input logic ir, input int n, input logic [N-1:0] din, output logic [N-1:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  task automatic float_tms(input int n);
    logic q;
    tms_oe <= 1'b0;
    repeat (n) step(1'b0, 1'b1, q);
    tms_oe <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: Self-checking bench for the test access port.
// Assumes: Smallest boundary register variant.
// Notes:   tms is pulled up so a released line reads high.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int L = 273;
  logic         ref_clk;
  logic         resetn;
  logic [L-1:0] pin_in;
  logic [L-1:0] core_out;
  logic [L-1:0] pin_out;
  logic [2:0]   ir_active;
  logic         tck;
  logic         tms_o;
  logic         tms_oe;
  logic         tdi;
  logic         tdo;
  logic         tdo_oe;
  tri1          tms_w;
  int           bad_count;
  int           n_compared;
  assign tms_w = tms_oe ? tms_o : 1'bz;
  bst_tap #(.BSR_LEN(L)) dut (.ref_clk(ref_clk), .resetn(resetn), .tck(tck), .tms(tms_w), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .ir_active(ir_active));
  bst_ctl_model #(.N(L)) ctl (.ref_clk(ref_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck_o(tck), .tms_o(tms_o),
    .tms_oe(tms_oe), .tdi_o(tdi));
  task automatic compare(input string nm, input logic [L-1:0] e, input logic [L-1:0] s);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic load_ir(input logic [2:0] code);
    logic [L-1:0] cap;
    ctl.shift(1'b1, 3, L'(code), cap);
    compare("ir capture", L'(3'h1), cap);
    compare("ir active", L'(code), L'(ir_active));
  endtask
  task automatic t_sample_extest();
    logic [L-1:0] d;
    pin_in <= {91{3'b011}};
    load_ir(bst_pkg::INS_SAMPLE);
    ctl.shift(1'b0, L, {91{3'b110}}, d);
    compare("sample capture", {91{3'b011}}, d);
    compare("core pins", core_out, pin_out);
    load_ir(bst_pkg::INS_EXTEST);
    core_out <= ~core_out;
    pin_in <= {91{3'b100}};
    repeat (4) @(posedge ref_clk);
    compare("preload at pins", {91{3'b110}}, pin_out);
    ctl.shift(1'b0, L, {91{3'b001}}, d);
    compare("extest capture", {91{3'b100}}, d);
    compare("extest drive", {91{3'b001}}, pin_out);
  endtask
  task automatic t_bypass();
    logic [2:0]   codes [3] = '{bst_pkg::INS_BYPASS, 3'h3, 3'h6};
    logic [L-1:0] d;
    foreach (codes[k])
    begin
      load_ir(codes[k]);
      ctl.shift(1'b0, 9, L'(9'h1a5), d);
      compare("bypass data", L'({8'ha5, 1'b0}), d);
      compare("bypass core", core_out, pin_out);
    end
  endtask
  task automatic t_float();
    load_ir(bst_pkg::INS_EXTEST);
    ctl.float_tms(5);
    compare("released tms reset", L'(bst_pkg::INS_BYPASS), L'(ir_active));
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    give_verdict();
  end
  initial
  begin
    logic q;
    resetn = 1'b0;
    pin_in = '0;
    core_out = {91{3'b101}};
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    compare("reset ir", L'(bst_pkg::INS_BYPASS), L'(ir_active));
    compare("reset oe", L'(1'b0), L'(tdo_oe));
    compare("reset pins", core_out, pin_out);
    ctl.step(1'b0, 1'b1, q);
    t_sample_extest();
    t_bypass();
    t_float();
    give_verdict();
  end
endmodule
`default_nettype wire
